// >>> src/eeg_core.sv
// Top of the gain control block: register file, gain transfer on vblank,
// soft reset, lock tracking and output gating of the video stream.
// Assumes pixel stream and APB share pclk; filter datapath sits downstream
// and consumes the working gains and the gated stream.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps

module eeg_core
	import eeg_pkg::*;
#(
	parameter int          DATA_WIDTH     = 8, // Build-time width: 8, 10 or 12 only
	parameter logic [63:0] TIMEOUT_CYCLES = 64'(EEG_TIMEOUT_CYCLES),
	parameter logic        EVAL_BUILD     = 1'b1
)
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	input  wire eeg_timing_s             timing_in,
	input  wire logic [3*DATA_WIDTH-1:0] video_data_in,
	output eeg_timing_s                  timing_out,
	output logic [3*DATA_WIDTH-1:0]      video_data_out,
	output eeg_gains_s                   working_gains
);

	localparam int VW = 3 * DATA_WIDTH;

	typedef struct packed {
		logic             enable;
		logic             gain_transfer_on;
		logic             soft_reset;
		eeg_gains_s       staged;
		eeg_gains_s       working;
		logic             vblank_seen;
		logic             locked;
		eeg_timing_s      arm;
		eeg_timing_s      t_out;
		logic [VW-1:0]    d_out;
	} eeg_main_state_s;

	eeg_main_state_s st_r;
	eeg_main_state_s st_nxt;

	eeg_regreq_s req;
	logic [31:0] rd_word;
	logic        timed_out;
	logic        vblank_rise;
	logic        running;
	eeg_timing_s t_gated;

	// Bus handshake kept apart from the register contents
	eeg_apb_port u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.rd_word (rd_word),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.req     (req)
	);

	// Evaluation expiry; a production build leaves the timer idle
	eeg_eval_timer #(
		.LIMIT (TIMEOUT_CYCLES),
		.ARMED (EVAL_BUILD)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.expired (timed_out)
	);

	// Processing runs only when enabled and out of soft reset
	assign running     = st_r.enable && !st_r.soft_reset;
	assign vblank_rise = timing_in.vblank && !st_r.vblank_seen;

	// Read multiplexer; reserved bits read as zero
	always_comb
	begin
		rd_word = EEG_WORD_ZERO;
		case (req.addr)
			EEG_CTRL_OFS:
			begin
				rd_word[EEG_CTRL_ENABLE_BIT] = st_r.enable;
				rd_word[EEG_CTRL_XFER_BIT]   = st_r.gain_transfer_on;
				rd_word[EEG_CTRL_SRST_BIT]   = st_r.soft_reset;
			end
			EEG_STATUS_OFS:
			begin
				rd_word[EEG_STAT_TIMEOUT_BIT] = timed_out;
				rd_word[EEG_STAT_RUNNING_BIT] = running;
				rd_word[EEG_STAT_LOCKED_BIT]  = st_r.locked;
			end
			EEG_GAIN_H_OFS:   rd_word[EEG_GAIN_W-1:0] = st_r.staged.horizontal_gain;
			EEG_GAIN_V_OFS:   rd_word[EEG_GAIN_W-1:0] = st_r.staged.vertical_gain;
			EEG_GAIN_D_OFS:   rd_word[EEG_GAIN_W-1:0] = st_r.staged.diagonal_gain;
			EEG_GAIN_LAP_OFS: rd_word[EEG_GAIN_W-1:0] = st_r.staged.second_derivative_gain;
			EEG_ACTIVE_OFS:   rd_word[4*EEG_GAIN_W-1:0] = st_r.working;
			default:          rd_word = EEG_WORD_ZERO;
		endcase
	end

	// Timing outputs pass once each input has been seen low after a restart
	always_comb
	begin
		t_gated.vblank       = timing_in.vblank && st_r.arm.vblank;
		t_gated.hblank       = timing_in.hblank && st_r.arm.hblank;
		t_gated.active_video = timing_in.active_video && st_r.arm.active_video;
	end

	// Next state of control, gains and output stage
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.vblank_seen = timing_in.vblank;

		// Register writes
		if (req.wr_stb)
		begin
			case (req.addr)
				EEG_CTRL_OFS:
				begin
					st_nxt.enable     = req.wdata[EEG_CTRL_ENABLE_BIT];
					st_nxt.soft_reset = req.wdata[EEG_CTRL_SRST_BIT];
					// Transfer bit is frozen while the core is disabled
					if (st_r.enable)
						st_nxt.gain_transfer_on = req.wdata[EEG_CTRL_XFER_BIT];
				end
				// Staged gains accept writes whatever the transfer state
				EEG_GAIN_H_OFS:
					st_nxt.staged.horizontal_gain = eeg_gain_clamp(req.wdata);
				EEG_GAIN_V_OFS:
					st_nxt.staged.vertical_gain = eeg_gain_clamp(req.wdata);
				EEG_GAIN_D_OFS:
					st_nxt.staged.diagonal_gain = eeg_gain_clamp(req.wdata);
				EEG_GAIN_LAP_OFS:
					st_nxt.staged.second_derivative_gain = eeg_gain_clamp(req.wdata);
				default:
					st_nxt.staged = st_r.staged;
			endcase
		end

		// Working gains follow staged ones at vblank rise with transfer on, and take the reset gains on soft reset
		if (running && st_r.gain_transfer_on && vblank_rise)
			st_nxt.working = st_r.staged;

		// Lock: first vblank rise after a restart marks valid frame timing
		if (running && vblank_rise)
			st_nxt.locked = 1'b1;

		// Re-arm each timing line once it is seen low
		if (running)
		begin
			if (!timing_in.vblank)
				st_nxt.arm.vblank = 1'b1;
			if (!timing_in.hblank)
				st_nxt.arm.hblank = 1'b1;
			if (!timing_in.active_video)
				st_nxt.arm.active_video = 1'b1;
		end

		// Output stage; data held at zero until locked so a partial frame is dark
		if (running)
		begin
			st_nxt.t_out = t_gated;
			st_nxt.d_out = st_r.locked ? video_data_in : '0;
		end
		else
		begin
			st_nxt.t_out = '0;
			st_nxt.d_out = '0;
			st_nxt.locked = 1'b0;
			st_nxt.arm    = '0;
		end

		// Evaluation expiry blanks the pixel data for good
		if (timed_out)
			st_nxt.d_out = '0;

		// Soft reset cuts in mid-frame; tearing is accepted for a fast stop
		if (st_nxt.soft_reset)
		begin
			st_nxt.staged.horizontal_gain        = EEG_GAIN_RESET;
			st_nxt.staged.vertical_gain          = EEG_GAIN_RESET;
			st_nxt.staged.diagonal_gain          = EEG_GAIN_RESET;
			st_nxt.staged.second_derivative_gain = EEG_GAIN_RESET;
			st_nxt.working = st_nxt.staged;
			st_nxt.t_out   = '0;
			st_nxt.d_out   = '0;
			st_nxt.locked  = 1'b0;
			st_nxt.arm     = '0;
		end
	end

	// All state resets on hardware reset, gains to EEG_GAIN_RESET, register port included
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.staged.horizontal_gain        <= EEG_GAIN_RESET;
			st_r.staged.vertical_gain          <= EEG_GAIN_RESET;
			st_r.staged.diagonal_gain          <= EEG_GAIN_RESET;
			st_r.staged.second_derivative_gain <= EEG_GAIN_RESET;
			st_r.working.horizontal_gain        <= EEG_GAIN_RESET;
			st_r.working.vertical_gain          <= EEG_GAIN_RESET;
			st_r.working.diagonal_gain          <= EEG_GAIN_RESET;
			st_r.working.second_derivative_gain <= EEG_GAIN_RESET;
		end
		else
			st_r <= st_nxt;
	end

	assign timing_out     = st_r.t_out;
	assign video_data_out = st_r.d_out;
	assign working_gains  = st_r.working;

endmodule

// >>> src/eeg_pkg.sv
// Package for the edge enhancement gain control block: register map,
// field positions, reset values, timing constants and carrier types.
// Assumes a single 100 MHz clock shared by the APB port and the video side.
//
// Behaviour
// - Evaluation build zeroes its video output after about eight hours of running.
// - Writing the enable bit as one starts the processing instance.
// - Writing the enable bit as zero stops the processing instance.
// - Soft reset acts in the same cycle, without waiting for frame boundaries.
// - During soft reset gains reset, pixel output is zero, timing outputs idle.
// - After soft reset clears, core relocks on input timing and resumes.
// - With transfer on, working gains load staged values at vblank rising edge.
// - With transfer off, gain writes are stored but processing ignores them.
// - Transfer control writes take effect only while the core is enabled.
// - Registers read back as 32-bit words; writes carry full 32-bit words.
// - Component width is a build parameter of 8, 10 or 12, default 8.
// - Four direction gains are writable at run time while the core runs.
// - Gains run 0 to 2 in quarter steps; core accepts that whole range.
// - One reset clears the whole core, register port included.
// - Register reads and writes go over the memory-mapped register bus.
package eeg_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] EEG_CTRL_OFS     = 8'h00;
	localparam logic [7:0] EEG_STATUS_OFS   = 8'h04;
	localparam logic [7:0] EEG_GAIN_H_OFS   = 8'h08;
	localparam logic [7:0] EEG_GAIN_V_OFS   = 8'h0c;
	localparam logic [7:0] EEG_GAIN_D_OFS   = 8'h10;
	localparam logic [7:0] EEG_GAIN_LAP_OFS = 8'h14;
	localparam logic [7:0] EEG_ACTIVE_OFS   = 8'h18;

	// Control word bit positions
	localparam int EEG_CTRL_ENABLE_BIT = 0;
	localparam int EEG_CTRL_XFER_BIT   = 1;
	localparam int EEG_CTRL_SRST_BIT   = 2;

	// Status word bit positions
	localparam int EEG_STAT_TIMEOUT_BIT = 0;
	localparam int EEG_STAT_RUNNING_BIT = 1;
	localparam int EEG_STAT_LOCKED_BIT  = 2;

	// Gains in quarter units: 0 .. 8 means 0.0 .. 2.0
	localparam int               EEG_GAIN_W     = 4;
	localparam logic [3:0]       EEG_GAIN_MAX   = 4'h8;
	localparam logic [3:0]       EEG_GAIN_RESET = 4'h4;
	localparam logic [31:0]      EEG_WORD_ZERO  = 32'h0000_0000;

	// Evaluation timeout
	localparam longint EEG_CLK_HZ         = 100_000_000;
	localparam longint EEG_TIMEOUT_HOURS  = 8;
	localparam longint EEG_TIMEOUT_CYCLES = EEG_TIMEOUT_HOURS * 3600 * EEG_CLK_HZ;

	typedef logic [EEG_GAIN_W-1:0] eeg_gain_t;

	// One set of direction gains
	typedef struct packed {
		eeg_gain_t horizontal_gain;
		eeg_gain_t vertical_gain;
		eeg_gain_t diagonal_gain;
		eeg_gain_t second_derivative_gain;
	} eeg_gains_s;

	// Video timing strobes
	typedef struct packed {
		logic vblank;
		logic hblank;
		logic active_video;
	} eeg_timing_s;

	// Register access handed from the bus port to the register file
	typedef struct packed {
		logic        wr_stb;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} eeg_regreq_s;

	// Mapped, word aligned register address
	function automatic logic eeg_reg_hit(input logic [7:0] addr);
		eeg_reg_hit = (addr[1:0] == 2'b00) && (addr <= EEG_ACTIVE_OFS);
	endfunction

	// Clamp a written value to the legal gain range
	function automatic eeg_gain_t eeg_gain_clamp(input logic [31:0] v);
		eeg_gain_clamp = (v > 32'(EEG_GAIN_MAX)) ? EEG_GAIN_MAX : v[EEG_GAIN_W-1:0];
	endfunction

endpackage

// >>> src/eeg_apb_port.sv
// APB slave handshake for the gain control register file.
// Assumes an APB master; the register file answers reads combinationally.
`timescale 1ns/10ps

module eeg_apb_port
	import eeg_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] rd_word,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output eeg_regreq_s      req
);

	typedef struct packed {
		logic        ready;
		logic [31:0] rdata;
		logic        err;
	} eeg_apb_state_s;

	eeg_apb_state_s st_r;
	eeg_apb_state_s st_nxt;

	// One wait state: data and error are registered at the same edge as pready rises
	always_comb
	begin
		st_nxt = '0; // Answer stands one cycle, then error and data drop
		if (psel && penable && !st_r.ready)
		begin
			st_nxt.ready = 1'b1;
			st_nxt.err   = !eeg_reg_hit(paddr);
			st_nxt.rdata = (!pwrite && eeg_reg_hit(paddr)) ? rd_word : EEG_WORD_ZERO;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Write lands at the completing edge only, and only on a mapped word
	assign req.wr_stb = psel && penable && pwrite && st_r.ready && !st_r.err;
	assign req.addr   = paddr;
	assign req.wdata  = pwdata;

	assign pready  = st_r.ready;
	assign prdata  = st_r.rdata;
	assign pslverr = st_r.err;

endmodule

// >>> src/eeg_eval_timer.sv
// Running-time counter for the evaluation build.
// Assumes one free running clock; only the hardware reset clears expiry.
`timescale 1ns/10ps

module eeg_eval_timer
	import eeg_pkg::*;
#(
	parameter logic [63:0] LIMIT = 64'(EEG_TIMEOUT_CYCLES),
	parameter logic        ARMED = 1'b1
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      expired
);

	typedef struct packed {
		logic [63:0] count;
		logic        done;
	} eeg_timer_state_s;

	eeg_timer_state_s st_r;
	eeg_timer_state_s st_nxt;

	// Counts until the limit, then stays expired; 64 bits never wrap
	always_comb
	begin
		st_nxt = st_r;
		if (ARMED && !st_r.done)
		begin
			st_nxt.count = st_r.count + 64'h1;
			st_nxt.done  = (st_nxt.count >= LIMIT);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign expired = st_r.done;

endmodule

// >>> testbench/eeg_core_monitor.sv
// Checker for the gain control block, watching only its top ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps

module eeg_core_monitor
	import eeg_pkg::*;
#(
	parameter int          DATA_WIDTH     = 8,
	parameter logic [63:0] TIMEOUT_CYCLES = 64'd200,
	parameter logic        EVAL_BUILD     = 1'b1
)
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic                    pready,
	input  wire logic [31:0]             prdata,
	input  wire logic                    pslverr,
	input  wire eeg_timing_s             timing_in,
	input  wire logic [3*DATA_WIDTH-1:0] video_data_in,
	input  wire eeg_timing_s             timing_out,
	input  wire logic [3*DATA_WIDTH-1:0] video_data_out,
	input  wire eeg_gains_s              working_gains
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [63:0] cyc_r;
	logic [3:0]  vb_r;
	logic [1:0]  srst_r;
	logic        ctrl_wr;
	logic        recent;
	logic [2:0]  t_o;
	logic [2:0]  t_i;
	logic [15:0] wg;
	// Completed control write, and recent causes of a gain change
	assign ctrl_wr = psel && penable && pready && pwrite && (paddr == EEG_CTRL_OFS);
	assign recent = (|(vb_r[2:0] & ~vb_r[3:1])) || (|srst_r);
	assign t_o = timing_out;
	assign t_i = timing_in;
	assign wg = working_gains;
	// History kept short: a gain load lands within two edges of its cause
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc_r <= 64'h0;
			vb_r <= 4'h0;
			srst_r <= 2'h0;
		end
		else
		begin
			cyc_r <= cyc_r + 64'h1;
			vb_r <= {vb_r[2:0], timing_in.vblank};
			srst_r <= {srst_r[0], ctrl_wr && pwdata[EEG_CTRL_SRST_BIT]};
		end
	end

	a_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_err_zero_data: assert property (pslverr |-> prdata == 32'h0)
		else $error("read data on refused access");
	a_srst_blanks: assert property (ctrl_wr && pwdata[EEG_CTRL_SRST_BIT] |=> video_data_out == '0 && t_o == 3'h0 && wg == 16'h4444)
		else $error("soft reset not at once");
	// Enable is registered first, so the outputs fall one edge later
	a_disable_blanks: assert property (ctrl_wr && !pwdata[EEG_CTRL_ENABLE_BIT] |=> ##1
		video_data_out == '0 && t_o == 3'h0)
		else $error("disable left output running");
	a_gain_hold: assert property ($changed(wg) |-> recent)
		else $error("working gains changed without cause");
	a_eval_blank: assert property (EVAL_BUILD && cyc_r > TIMEOUT_CYCLES + 64'd2 |-> video_data_out == '0)
		else $error("output alive after evaluation timeout");
	a_timing_follow: assert property ((t_o & ~$past(t_i)) == 3'h0)
		else $error("timing output without input");
	a_data_follow: assert property (video_data_out != '0 |-> video_data_out == $past(video_data_in))
		else $error("data output not delayed input");
	cover property (ctrl_wr && pwdata[EEG_CTRL_SRST_BIT]);
	cover property (pslverr);
	cover property ($changed(wg) && !srst_r[0] && !srst_r[1]);
endmodule

bind eeg_core eeg_core_monitor #(.DATA_WIDTH(DATA_WIDTH), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.EVAL_BUILD(EVAL_BUILD)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .timing_in(timing_in), .video_data_in(video_data_in),
	.timing_out(timing_out), .video_data_out(video_data_out), .working_gains(working_gains));

// >>> testbench/eeg_host_model.sv
// Host side of the register port: a bus master running one transfer at a time.
// Assumes only the bench calls xfer and nothing else drives the bus.
`timescale 1ns/10ps

module eeg_host_model
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// Idle bus from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Setup, then access held until ready is sampled; full words only
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits for the answer; only the bench timeout ends a hang
		do
		begin
			@(posedge pclk);
		end
		while (!pready);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Released lines must not look still valid
		pwdata <= ~d;
	endtask
endmodule

// >>> testbench/edge_enhance_gain_control_bench.sv
// Self-checking bench: register traffic through the host model, a small
// synthetic raster with random pixels, random legal gains.
// Assumes the host model and the bound monitor are compiled first.
`timescale 1ns/10ps

module edge_enhance_gain_control_bench import eeg_pkg::*;;
	localparam int TMO = 4000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	eeg_timing_s tin, tout, tin_r;
	logic [23:0] din, dout, din_r;
	eeg_gains_s  wg;
	logic [3:0]  g [4];
	int          err_count, checks_done, cyc, col, row, i;

	eeg_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	eeg_core #(.DATA_WIDTH(8), .TIMEOUT_CYCLES(64'(TMO)), .EVAL_BUILD(1'b1)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.timing_in(tin), .video_data_in(din), .timing_out(tout), .video_data_out(dout),
		.working_gains(wg));

	// Clock
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	// Raster of 10 columns by 7 rows, last three rows blanked
	always @(posedge pclk)
	begin
		col <= (col == 9) ? 0 : col + 1;
		if (col == 9)
			row <= (row == 6) ? 0 : row + 1;
		tin.vblank <= (row >= 4);
		tin.hblank <= (col >= 8);
		tin.active_video <= (row < 4) && (col < 8);
		din <= 24'($urandom);
		din_r <= din;
		tin_r <= tin;
		cyc <= cyc + 1;
		if (cyc == TMO + 2000)
		begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
		u_host.xfer(1'b0, a, 32'h0, rd, err);
		chk(rd, want);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd, err);
	endtask
	task automatic frames(input int n);
		repeat (n * 70) @(posedge pclk);
	endtask
	// Locked stream shows each input sample one cycle later
	task automatic chk_pass();
		@(posedge pclk);
		#1;
		chk({8'h0, dout}, {8'h0, din_r});
		chk({29'h0, tout}, {29'h0, tin_r});
	endtask

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		{col, row, cyc, err_count, checks_done} = '0;
		tin = '0;
		din = '0;
		din_r = '0;
		tin_r = '0;
		rd = $urandom(72875);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(EEG_CTRL_OFS, 32'h0);
		rd_chk(EEG_ACTIVE_OFS, 32'h4444);
		u_host.xfer(1'b0, 8'h1c, 32'h0, rd, err);
		chk({31'h0, err}, 32'h1);
		wr(EEG_CTRL_OFS, 32'h2);
		rd_chk(EEG_CTRL_OFS, 32'h0);
		wr(EEG_GAIN_H_OFS, 32'hffff_ffff);
		rd_chk(EEG_GAIN_H_OFS, 32'h8);
		// Gains staged with transfer off, legal quarter steps only
		for (i = 0; i < 4; i++)
		begin
			g[i] = 4'($urandom_range(8));
			wr(EEG_GAIN_H_OFS + 8'(4 * i), {28'h0, g[i]});
			rd_chk(EEG_GAIN_H_OFS + 8'(4 * i), {28'h0, g[i]});
		end
		wr(EEG_CTRL_OFS, 32'h1);
		frames(2);
		chk({16'h0, wg}, 32'h4444);
		rd_chk(EEG_STATUS_OFS, 32'h6);
		chk_pass();
		wr(EEG_CTRL_OFS, 32'h3);
		frames(2);
		chk({16'h0, wg}, {16'h0, g[0], g[1], g[2], g[3]});
		wr(EEG_CTRL_OFS, 32'h1);
		// Soft reset in mid-frame, then release and relock
		wr(EEG_CTRL_OFS, 32'h5);
		#1;
		chk({8'h0, dout}, 32'h0);
		chk({16'h0, wg}, 32'h4444);
		frames(1);
		chk({29'h0, tout}, 32'h0);
		rd_chk(EEG_GAIN_H_OFS, 32'h4);
		wr(EEG_CTRL_OFS, 32'h1);
		frames(2);
		chk_pass();
		wr(EEG_CTRL_OFS, 32'h0);
		@(posedge pclk); // Outputs drop one edge after enable clears
		#1;
		chk({8'h0, dout}, 32'h0);
		frames(1);
		chk({29'h0, tout}, 32'h0);
		// Run on past the shortened evaluation limit
		wr(EEG_CTRL_OFS, 32'h1);
		while (cyc < TMO + 64)
			@(posedge pclk);
		#1;
		chk({8'h0, dout}, 32'h0);
		rd_chk(EEG_STATUS_OFS, 32'h7);
		conclude();
	end
endmodule
